// File: common/rc_pkg.sv
// Constants shared by the reference clock output generator
`default_nettype none
package rc_pkg;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned REG_W = 16;
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] DIV_OFS = 12'h004;
    localparam logic [11:0] TRIM_OFS = 12'h008;
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] DIV_RST = 16'h0000;
    localparam logic [15:0] TRIM_RST = 16'h0000;
    localparam int unsigned EN_BIT = 15;
    localparam int unsigned IDLE_BIT = 13;
    localparam int unsigned PIN_BIT = 12;
    localparam int unsigned SLEEP_BIT = 11;
    localparam int unsigned SW_BIT = 9;
    localparam int unsigned ACT_BIT = 8;
    localparam int unsigned SEL_LSB = 0;
    localparam int unsigned SEL_W = 4;
    localparam int unsigned DIV_LSB = 0;
    localparam int unsigned DIV_W = 15;
    localparam int unsigned TRIM_LSB = 7;
    localparam int unsigned TRIM_W = 9;
    localparam int unsigned NUM_SRC = 8;
    localparam logic [3:0] SRC_SYSOSC = 4'h0;
    localparam logic [3:0] SRC_PERIPH = 4'h1;
    localparam logic [3:0] SRC_PRIMARY_OSC = 4'h2;
    localparam logic [3:0] SRC_FRC = 4'h3;
    localparam logic [3:0] SRC_LOW_POWER_RC_OSC = 4'h4;
    localparam logic [3:0] SRC_SECONDARY_OSC = 4'h5;
    localparam logic [3:0] SRC_PLL = 4'h6;
    localparam logic [3:0] SRC_RSVD = 4'h7;
    localparam logic [3:0] SRC_REFIN = 4'h8;
    localparam logic [2:0] REFIN_IDX = 3'h7;
    localparam logic [2:0] CURRENT_SYSTEM_OSC_FRCPLL = 3'h1;
    localparam logic [2:0] CURRENT_SYSTEM_OSC_PRIPLL = 3'h3;
endpackage
`default_nettype wire

// File: hdl/level_sync.sv
// Three-stage synchroniser whose output moves once two stages agree
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
    parameter int unsigned WIDTH = 8
)(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] level_r
);
    logic [WIDTH-1:0] stage1_r;
    logic [WIDTH-1:0] stage2_r;
    logic [WIDTH-1:0] stage3_r;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            stage1_r <= '0;
            stage2_r <= '0;
            stage3_r <= '0;
        end
        else
        begin
            stage1_r <= async_in;
            stage2_r <= stage1_r;
            stage3_r <= stage2_r;
        end
    end

    // Per bit: follow when stages two and three agree, else hold
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            level_r <= '0;
        end
        else
        begin
            level_r <= (stage2_r & stage3_r) | (level_r & (stage2_r | stage3_r));
        end
    end
endmodule
`default_nettype wire

// File: hdl/reference_clock_output_generator.sv
// Reference clock output generator: APB registers, source mux, fractional divider
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Enable bit 15 of control starts the generator; clearing it stops it.
// - Output frequency is input over twice (divisor plus trim/512).
// - Divisor zero passes the selected source through undivided.
// - Divisor is 15 bits at 14..0; value n divides by 2n.
// - Trim is 9 bits at 15..7, trim bit 0 at 15; step 1/512.
// - Software waits switch bit low, writes values, sets it, waits clear.
// - Switch bit stays high until new divisor and trim take effect.
// - Four-bit source select at 3..0 picks one of eight sources.
// - Select zero follows the system clock, tracking its switches.
// - Sleep output needs run-in-sleep set and a source alive in sleep.
// - Pin drive bit 12 gates the clock onto the pin.
// - Read-only active bit 8 shows activity, clears after disable.
// - PLL serves the output when not system clock; its input per config.
// - Fixed oscillator/2 output has its own enable.
// - Unimplemented register bits ignore writes and read zero.
module reference_clock_output_generator #(
    parameter int unsigned ADDR_W = rc_pkg::ADDR_W
)(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sys_osc_clk,
    input wire logic periph_clk,
    input wire logic primary_osc,
    input wire logic fast_internal_rc,
    input wire logic low_power_rc_osc,
    input wire logic secondary_osc,
    input wire logic pll_clk,
    input wire logic reference_input_pin,
    input wire logic [2:0] current_system_osc,
    input wire logic pll_source_config,
    input wire logic fixed_clock_out_config,
    input wire logic idle_mode,
    input wire logic sleep_mode,
    input wire logic source_sleep_ok,
    output logic reference_clock_out,
    output logic refclk_pin_oe,
    output logic fixed_clock_out,
    output logic pll_free_for_ref,
    output logic pll_in_from_primary_osc
);
    localparam int unsigned DIV_W = rc_pkg::DIV_W;
    localparam int unsigned TRIM_W = rc_pkg::TRIM_W;
    localparam int unsigned CNT_W = DIV_W + 1;

    logic gen_enable_r;
    logic stop_in_idle_r;
    logic pin_drive_enable_r;
    logic run_in_sleep_r;
    logic divider_switch_request_r;
    logic gen_active_status_r;
    logic [rc_pkg::SEL_W-1:0] source_select_r;
    logic [DIV_W-1:0] integer_divisor_r;
    logic [TRIM_W-1:0] trim_field_r;
    logic [DIV_W-1:0] div_live_r;
    logic [TRIM_W-1:0] frac_live_r;
    logic [TRIM_W-1:0] fractional_trim;

    logic setup_ph;
    logic access_ph;
    logic addr_ok;
    logic wr_ctrl;
    logic wr_div;
    logic wr_trim;
    logic [rc_pkg::REG_W-1:0] ctrl_word;
    logic [rc_pkg::REG_W-1:0] read_word;

    logic [rc_pkg::NUM_SRC-1:0] src_lvl;
    logic sel_lvl;
    logic sel_prev_r;
    logic sys_prev_r;
    logic src_rise;
    logic run;
    logic counting;
    logic pass_mode;
    logic gen_out_r;
    logic [CNT_W-1:0] edge_cnt_r;
    logic [CNT_W-1:0] edge_cnt_inc;
    logic [CNT_W-1:0] half_len;
    logic [TRIM_W-1:0] frac_acc_r;
    logic extra_r;
    logic [TRIM_W:0] frac_sum;
    logic half_done;
    logic at_boundary;
    logic load_now;

    // APB decode
    assign setup_ph = psel && !penable;
    assign access_ph = psel && penable && pready;
    assign addr_ok = (paddr == rc_pkg::CTRL_OFS) || (paddr == rc_pkg::DIV_OFS)
        || (paddr == rc_pkg::TRIM_OFS);
    assign wr_ctrl = access_ph && pwrite && (paddr == rc_pkg::CTRL_OFS);
    assign wr_div = access_ph && pwrite && (paddr == rc_pkg::DIV_OFS);
    assign wr_trim = access_ph && pwrite && (paddr == rc_pkg::TRIM_OFS);

    // Control word image, unused positions stay zero
    always_comb
    begin
        ctrl_word = '0;
        ctrl_word[rc_pkg::EN_BIT] = gen_enable_r;
        ctrl_word[rc_pkg::IDLE_BIT] = stop_in_idle_r;
        ctrl_word[rc_pkg::PIN_BIT] = pin_drive_enable_r;
        ctrl_word[rc_pkg::SLEEP_BIT] = run_in_sleep_r;
        ctrl_word[rc_pkg::SW_BIT] = divider_switch_request_r;
        ctrl_word[rc_pkg::ACT_BIT] = gen_active_status_r;
        ctrl_word[rc_pkg::SEL_LSB +: rc_pkg::SEL_W] = source_select_r;
    end

    always_comb
    begin
        read_word = '0;
        if (paddr == rc_pkg::CTRL_OFS)
        begin
            read_word = ctrl_word;
        end
        else if (paddr == rc_pkg::DIV_OFS)
        begin
            read_word[rc_pkg::DIV_LSB +: DIV_W] = integer_divisor_r;
        end
        else if (paddr == rc_pkg::TRIM_OFS)
        begin
            read_word[rc_pkg::TRIM_LSB +: TRIM_W] = trim_field_r;
        end
    end

    // One-cycle access phase; unmapped addresses answer with an error
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= setup_ph;
            pslverr <= setup_ph && !addr_ok;
            prdata <= (setup_ph && !pwrite) ? {16'h0000, read_word} : 32'h0000_0000;
        end
    end

    // Control register
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            gen_enable_r <= rc_pkg::CTRL_RST[rc_pkg::EN_BIT];
            stop_in_idle_r <= rc_pkg::CTRL_RST[rc_pkg::IDLE_BIT];
            pin_drive_enable_r <= rc_pkg::CTRL_RST[rc_pkg::PIN_BIT];
            run_in_sleep_r <= rc_pkg::CTRL_RST[rc_pkg::SLEEP_BIT];
            source_select_r <= rc_pkg::CTRL_RST[rc_pkg::SEL_LSB +: rc_pkg::SEL_W];
        end
        else if (wr_ctrl)
        begin
            gen_enable_r <= pwdata[rc_pkg::EN_BIT];
            stop_in_idle_r <= pwdata[rc_pkg::IDLE_BIT];
            pin_drive_enable_r <= pwdata[rc_pkg::PIN_BIT];
            run_in_sleep_r <= pwdata[rc_pkg::SLEEP_BIT];
            source_select_r <= pwdata[rc_pkg::SEL_LSB +: rc_pkg::SEL_W];
        end
    end

    // Switch request: software sets, hardware clears, a new set wins
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            divider_switch_request_r <= rc_pkg::CTRL_RST[rc_pkg::SW_BIT];
        end
        else if (wr_ctrl && pwdata[rc_pkg::SW_BIT])
        begin
            divider_switch_request_r <= 1'b1;
        end
        else if (load_now)
        begin
            divider_switch_request_r <= 1'b0;
        end
    end

    // Divisor and trim staging registers
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            integer_divisor_r <= rc_pkg::DIV_RST[rc_pkg::DIV_LSB +: DIV_W];
            trim_field_r <= rc_pkg::TRIM_RST[rc_pkg::TRIM_LSB +: TRIM_W];
        end
        else
        begin
            if (wr_div)
            begin
                integer_divisor_r <= pwdata[rc_pkg::DIV_LSB +: DIV_W];
            end
            if (wr_trim)
            begin
                trim_field_r <= pwdata[rc_pkg::TRIM_LSB +: TRIM_W];
            end
        end
    end

    // Trim bit 0 sits at the top of the field, so reverse it
    always_comb
    begin
        for (int i = 0; i < TRIM_W; i++)
            fractional_trim[i] = trim_field_r[TRIM_W-1-i];
    end

    // Live values change only through the switch handshake
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            div_live_r <= rc_pkg::DIV_RST[rc_pkg::DIV_LSB +: DIV_W];
            frac_live_r <= '0;
        end
        else if (load_now)
        begin
            div_live_r <= integer_divisor_r;
            frac_live_r <= fractional_trim;
        end
    end

    level_sync #(
        .WIDTH(rc_pkg::NUM_SRC)
    ) u_src_sync (
        .clk(clk),
        .resetn(resetn),
        .async_in({reference_input_pin, pll_clk, secondary_osc, low_power_rc_osc,
            fast_internal_rc, primary_osc, periph_clk, sys_osc_clk}),
        .level_r(src_lvl)
    );

    // Source mux; reserved codes give a silent source
    always_comb
    begin
        sel_lvl = 1'b0;
        if (source_select_r == rc_pkg::SRC_REFIN)
        begin
            sel_lvl = src_lvl[rc_pkg::REFIN_IDX];
        end
        else if (source_select_r < rc_pkg::SRC_RSVD)
        begin
            // Code zero is the live system clock, so it tracks switches
            // Not guarded against changes while active
            sel_lvl = src_lvl[source_select_r[2:0]];
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sel_prev_r <= 1'b0;
            sys_prev_r <= 1'b0;
        end
        else
        begin
            sel_prev_r <= sel_lvl;
            sys_prev_r <= src_lvl[0];
        end
    end

    assign src_rise = sel_lvl && !sel_prev_r;

    // Run conditions for enable, idle and sleep
    assign run = gen_enable_r && !(idle_mode && stop_in_idle_r)
        && !(sleep_mode && !(run_in_sleep_r && source_sleep_ok));
    // A high output finishes its half period before stopping
    assign counting = run || gen_out_r;
    assign pass_mode = (div_live_r == '0);

    // Half period is divisor edges plus one when the trim accumulator carries
    assign frac_sum = {1'b0, frac_acc_r} + {1'b0, frac_live_r};
    assign half_len = {1'b0, div_live_r} + {{(CNT_W-1){1'b0}}, extra_r};
    assign edge_cnt_inc = edge_cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
    assign half_done = !pass_mode && counting && src_rise && (edge_cnt_inc >= half_len);

    // Load only when stopped, or while running when the output is high and about to fall
    always_comb
    begin
        if (!counting)
        begin
            at_boundary = 1'b1;
        end
        else if (pass_mode)
        begin
            at_boundary = gen_out_r && !sel_lvl;
        end
        else
        begin
            at_boundary = gen_out_r && half_done;
        end
    end

    assign load_now = divider_switch_request_r && at_boundary;

    // Generated clock
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            gen_out_r <= 1'b0;
        end
        else if (pass_mode)
        begin
            gen_out_r <= sel_lvl && counting;
        end
        else if (half_done)
        begin
            gen_out_r <= !gen_out_r && run;
        end
    end

    // Edge counter and fractional accumulator
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            edge_cnt_r <= '0;
            frac_acc_r <= '0;
            extra_r <= 1'b0;
        end
        else if (load_now || pass_mode || !counting)
        begin
            edge_cnt_r <= '0;
            frac_acc_r <= '0;
            extra_r <= 1'b0;
        end
        else if (half_done)
        begin
            edge_cnt_r <= '0;
            frac_acc_r <= frac_sum[TRIM_W-1:0];
            extra_r <= frac_sum[TRIM_W];
        end
        else if (src_rise)
        begin
            edge_cnt_r <= edge_cnt_inc;
        end
    end

    // Active status lingers until the output has returned low
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            gen_active_status_r <= rc_pkg::CTRL_RST[rc_pkg::ACT_BIT];
        end
        else
        begin
            gen_active_status_r <= gen_enable_r || gen_out_r;
        end
    end

    // Pin driver
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            reference_clock_out <= 1'b0;
            refclk_pin_oe <= 1'b0;
        end
        else
        begin
            reference_clock_out <= gen_out_r && pin_drive_enable_r;
            refclk_pin_oe <= pin_drive_enable_r;
        end
    end

    // Fixed half-rate oscillator output
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            fixed_clock_out <= 1'b0;
        end
        else if (!fixed_clock_out_config)
        begin
            fixed_clock_out <= 1'b0;
        end
        else if (src_lvl[0] && !sys_prev_r)
        begin
            fixed_clock_out <= !fixed_clock_out;
        end
    end

    // PLL availability and its input choice
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pll_free_for_ref <= 1'b0;
            pll_in_from_primary_osc <= 1'b0;
        end
        else if ((current_system_osc != rc_pkg::CURRENT_SYSTEM_OSC_FRCPLL)
            && (current_system_osc != rc_pkg::CURRENT_SYSTEM_OSC_PRIPLL))
        begin
            pll_free_for_ref <= 1'b1;
            pll_in_from_primary_osc <= pll_source_config;
        end
        else
        begin
            pll_free_for_ref <= 1'b0;
            pll_in_from_primary_osc <= (current_system_osc == rc_pkg::CURRENT_SYSTEM_OSC_PRIPLL);
        end
    end
endmodule
`default_nettype wire

// File: testbench/refgen_assertions.sv
// Port checker for the reference clock output generator
`timescale 1ns/1ps
`default_nettype none
module refgen_checker #(
    parameter int unsigned ADDR_W = 12
)(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [2:0] current_system_osc,
    input wire logic pll_source_config,
    input wire logic fixed_clock_out_config,
    input wire logic reference_clock_out,
    input wire logic refclk_pin_oe,
    input wire logic fixed_clock_out,
    input wire logic pll_free_for_ref,
    input wire logic pll_in_from_primary_osc
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    logic mapped;
    assign mapped = paddr == rc_pkg::CTRL_OFS || paddr == rc_pkg::DIV_OFS
        || paddr == rc_pkg::TRIM_OFS;
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence
    sequence s_read(a);
        psel && !penable && !pwrite && paddr == a;
    endsequence
    AST_ACCESS_FOLLOWS: assert property (s_setup |=> s_access) else $error("no ready after setup");
    AST_READY_CAUSE: assert property (pready |-> $past(psel && !penable)) else $error("stray ready");
    AST_ERR_UNMAPPED: assert property (s_setup |=> pslverr == !$past(mapped)) else $error("bad slverr");
    AST_UPPER_ZERO: assert property (pready |-> prdata[31:16] == 16'h0000)
        else $error("upper read bits set");
    AST_CTRL_GAPS: assert property (s_read(rc_pkg::CTRL_OFS) |=> (prdata & 32'h44f0) == 32'h0)
        else $error("unused control bits set");
    AST_PIN_GATE: assert property (!refclk_pin_oe |-> !reference_clock_out)
        else $error("clock on undriven pin");
    AST_PLL_FREE: assert property ($past(resetn, 2) |-> pll_free_for_ref ==
        ($past(current_system_osc) != rc_pkg::CURRENT_SYSTEM_OSC_FRCPLL
        && $past(current_system_osc) != rc_pkg::CURRENT_SYSTEM_OSC_PRIPLL)) else $error("pll free");
    AST_PLL_SRC: assert property ($past(resetn, 2) && pll_free_for_ref |->
        pll_in_from_primary_osc == $past(pll_source_config)) else $error("pll source");
    AST_FIXED_OFF: assert property ($past(resetn, 2) && !$past(fixed_clock_out_config) |->
        !fixed_clock_out) else $error("fixed clock while off");
endmodule
`default_nettype wire

// File: testbench/refclk_sink.sv
// Pin-side load model: counts reference clock edges and times the last period
`timescale 1ns/1ps
`default_nettype none
module refclk_sink (
    input wire logic refclk,
    input wire logic clr,
    output var int edges,
    output var int period_ns
);
    time t_last = 0;
    always @(posedge refclk or posedge clr)
    begin
        if (clr)
            edges <= 0;
        else
        begin
            edges <= edges + 1;
            period_ns <= int'($time - t_last);
            t_last <= $time;
        end
    end
endmodule
`default_nettype wire

// File: testbench/tb_reference_clock_output_generator.sv
// Self-checking bench for the reference clock output generator
`timescale 1ns/1ps
`default_nettype none
module tb_reference_clock_output_generator;
    localparam logic [15:0] EN = 16'h8000;
    localparam logic [15:0] RUN = 16'h9000;
    localparam logic [15:0] IDL = 16'h2000;
    localparam logic [15:0] SLP = 16'h0800;
    localparam logic [15:0] SW = 16'h0200;
    typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] r; logic e;} row_t;
    row_t rows [4] = '{'{rc_pkg::DIV_OFS, 32'hffffffff, 32'h00007fff, 1'b0},
        '{rc_pkg::TRIM_OFS, 32'hffffffff, 32'h0000ff80, 1'b0},
        '{rc_pkg::CTRL_OFS, 32'h000034ff, 32'h0000300f, 1'b0},
        '{12'h00c, 32'h00001234, 32'h00000000, 1'b1}};
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, reference_clock_out, refclk_pin_oe;
    logic fixed_clock_out, pll_free_for_ref, pll_in_from_primary_osc;
    logic src [8];
    logic [2:0] current_system_osc = 3'h0;
    logic pll_source_config = 1'b0;
    logic fixed_clock_out_config = 1'b0;
    logic idle_mode = 1'b0;
    logic sleep_mode = 1'b0;
    logic source_sleep_ok = 1'b0;
    logic sink_clr = 1'b0;
    int edges, period_ns;
    int fails = 0;
    int check_count = 0;
    always #2.5 clk = ~clk;
    // Source i has period 40 + 10 i ns, phased away from rising clk edges
    for (genvar i = 0; i < 8; i++)
    begin : g_src
        initial
        begin
            src[i] = 1'b0;
            #(1 + i);
            forever #(20 + 5 * i) src[i] = ~src[i];
        end
    end
    reference_clock_output_generator i_reference_clock_output_generator (
        .clk, .resetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
        .sys_osc_clk(src[0]), .periph_clk(src[1]), .primary_osc(src[2]),
        .fast_internal_rc(src[3]), .low_power_rc_osc(src[4]), .secondary_osc(src[5]),
        .pll_clk(src[6]), .reference_input_pin(src[7]), .current_system_osc,
        .pll_source_config, .fixed_clock_out_config, .idle_mode, .sleep_mode, .source_sleep_ok,
        .reference_clock_out, .refclk_pin_oe, .fixed_clock_out, .pll_free_for_ref,
        .pll_in_from_primary_osc);
    refclk_sink i_refclk_sink (.refclk(reference_clock_out), .clr(sink_clr), .edges, .period_ns);
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        int n;
        @(posedge clk);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        // Answer is taken at the rising edge that samples pready high
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
            check(32'h0, 32'h1);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(a, 1'b1, d, r, e);
    endtask
    task automatic rd_ctrl(output logic [31:0] r);
        logic e;
        apb(rc_pkg::CTRL_OFS, 1'b0, 32'h0, r, e);
    endtask
    task automatic wait_bit(input int b, input logic v, output logic got);
        logic [31:0] r;
        int n;
        n = 0;
        do
        begin
            rd_ctrl(r);
            n++;
        end
        while (r[b] !== v && n < 400);
        got = r[b];
    endtask
    task automatic measure();
        // Two cycles cover a pin edge still in the output register
        sink_clr <= 1'b1;
        repeat (2) @(posedge clk);
        sink_clr <= 1'b0;
        repeat (300) @(posedge clk);
    endtask
    // Divider is loaded while stopped, so a silent source cannot stall the switch
    task automatic cfg(input logic [15:0] c, input logic [15:0] dv, input logic [15:0] tr);
        logic g;
        wr(rc_pkg::CTRL_OFS, 32'h0);
        wait_bit(rc_pkg::ACT_BIT, 1'b0, g);
        wr(rc_pkg::DIV_OFS, {16'h0, dv});
        wr(rc_pkg::TRIM_OFS, {16'h0, tr});
        wait_bit(rc_pkg::SW_BIT, 1'b0, g);
        wr(rc_pkg::CTRL_OFS, {16'h0, (c & ~EN) | SW});
        wait_bit(rc_pkg::SW_BIT, 1'b0, g);
        check(g, 1'b0);
        wr(rc_pkg::CTRL_OFS, {16'h0, c});
        measure();
    endtask
    function automatic int per(input int c);
        if (c == 7 || c > 8)
            return 0;
        return 2 * (40 + 10 * (c == 8 ? 7 : c));
    endfunction
    task automatic finish_test();
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        #300000;
        fails++;
        finish_test();
    end
    initial
    begin
        logic [31:0] r;
        logic e;
        logic g;
        logic v;
        repeat (4) @(posedge clk);
        check({reference_clock_out, refclk_pin_oe, fixed_clock_out, pready}, 32'h0);
        resetn <= 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            apb(rows[i].a, 1'b0, 32'h0, r, e);
            check(r, 32'h0);
        end
        foreach (rows[i])
        begin
            apb(rows[i].a, 1'b1, rows[i].w, r, e);
            check(e, rows[i].e);
            apb(rows[i].a, 1'b0, 32'h0, r, e);
            check(r, rows[i].r);
            check(e, rows[i].e);
        end
        for (int c = 0; c < 16; c++)
        begin
            cfg(RUN | 16'(c), 16'h1, 16'h0);
            check(32'(per(c) == 0 ? edges : period_ns), 32'(per(c)));
        end
        cfg(RUN, 16'h1, 16'h0080);
        check(32'(period_ns), 32'h78);
        cfg(RUN | 16'h2, 16'h0, 16'h0);
        check(32'(period_ns), 32'h3c);
        cfg(RUN, 16'h14, 16'h0);
        repeat (30) @(posedge clk);
        wr(rc_pkg::DIV_OFS, 32'h1);
        wr(rc_pkg::CTRL_OFS, {16'h0, RUN | SW});
        rd_ctrl(r);
        check(r[rc_pkg::SW_BIT], 1'b1);
        wait_bit(rc_pkg::SW_BIT, 1'b0, g);
        check(g, 1'b0);
        measure();
        check(32'(period_ns), 32'h50);
        cfg(EN, 16'h1, 16'h0);
        check(32'(edges), 32'h0);
        check(refclk_pin_oe, 1'b0);
        rd_ctrl(r);
        check(r[rc_pkg::ACT_BIT], 1'b1);
        wr(rc_pkg::CTRL_OFS, {16'h0, RUN});
        wait_bit(rc_pkg::ACT_BIT, 1'b1, g);
        wr(rc_pkg::CTRL_OFS, 32'h0);
        wait_bit(rc_pkg::ACT_BIT, 1'b0, g);
        check(g, 1'b0);
        measure();
        check(32'(edges), 32'h0);
        check(reference_clock_out, 1'b0);
        idle_mode <= 1'b1;
        cfg(RUN | IDL, 16'h1, 16'h0);
        check(32'(edges), 32'h0);
        cfg(RUN, 16'h1, 16'h0);
        check(32'(period_ns), 32'h50);
        idle_mode <= 1'b0;
        sleep_mode <= 1'b1;
        source_sleep_ok <= 1'b1;
        cfg(RUN | SLP, 16'h1, 16'h0);
        check(32'(period_ns), 32'h50);
        source_sleep_ok <= 1'b0;
        measure();
        check(32'(edges), 32'h0);
        sleep_mode <= 1'b0;
        for (int i = 0; i < 16; i++)
        begin
            current_system_osc <= 3'(i);
            pll_source_config <= i[3];
            repeat (3) @(posedge clk);
            v = (i % 8 != 1) && (i % 8 != 3);
            check(pll_free_for_ref, v);
            check(pll_in_from_primary_osc, v ? i[3] : (i % 8 == 3));
        end
        fixed_clock_out_config <= 1'b1;
        repeat (10) @(posedge clk);
        v = fixed_clock_out;
        repeat (8) @(posedge clk);
        check(fixed_clock_out, !v);
        fixed_clock_out_config <= 1'b0;
        repeat (3) @(posedge clk);
        check(fixed_clock_out, 1'b0);
        // Reset in mid-run clears outputs and registers
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        check({reference_clock_out, refclk_pin_oe, pll_free_for_ref, pready}, 32'h0);
        resetn <= 1'b1;
        rd_ctrl(r);
        check(r, 32'h0);
        finish_test();
    end
endmodule
bind reference_clock_output_generator refgen_checker #(.ADDR_W(ADDR_W)) i_refgen_checker (
    .clk, .resetn, .paddr, .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
    .current_system_osc, .pll_source_config, .fixed_clock_out_config, .reference_clock_out,
    .refclk_pin_oe, .fixed_clock_out, .pll_free_for_ref, .pll_in_from_primary_osc);
`default_nettype wire
